// *** cphc_cfg.svh ***
// cphc_cfg.svh: constants of the pipeline hazard control block
`ifndef CPHC_CFG_SVH
`define CPHC_CFG_SVH
// ============================================================
// datapath widths, PC step, reset address and prefetch depth
`define CPHC_IW          32
`define CPHC_AW          32
`define CPHC_PC_STEP     32'h0000_0004
`define CPHC_RST_PC      32'h0000_0000
`define CPHC_PFB_DEPTH   4
// ============================================================
// instruction word fields
`define CPHC_CLS_HI      31
`define CPHC_CLS_LO      28
`define CPHC_RD_HI       27
`define CPHC_RD_LO       23
`define CPHC_RA_HI       22
`define CPHC_RA_LO       18
`define CPHC_RB_HI       17
`define CPHC_RB_LO       13
`define CPHC_IMM_HI      12
`define CPHC_IMM_LO      0
`define CPHC_SYNC_IMM    13'h0004
`define CPHC_REG_ZERO    5'h00
`endif

// *** cphc_pkg.sv ***
// cphc_pkg.sv: types shared by the pipeline hazard control block
`include "cphc_cfg.svh"
`default_nettype none
package cphc_pkg;
	// instruction class, coded in the class field in this order
	typedef enum logic [3:0] {
		CPHC_ALU, CPHC_LOAD, CPHC_STORE, CPHC_BSHIFT, CPHC_MUL, CPHC_DIV,
		CPHC_FPU, CPHC_STREAM, CPHC_BRANCH, CPHC_MEMORY_BARRIER_INSTR, CPHC_BRI
	} cphc_cls_e;
	typedef enum logic [1:0] {
		CPHC_FWD_NONE, CPHC_FWD_EX, CPHC_FWD_MEM, CPHC_FWD_WB
	} cphc_fwd_e;
	typedef struct packed {
		logic                valid;
		logic [`CPHC_AW-1:0] pc;
		logic [`CPHC_IW-1:0] instr;
	} cphc_stage_s;
endpackage
`default_nettype wire

// *** cphc_pfb_if.sv ***
// cphc_pfb_if.sv: link between fetch control and the prefetch buffer
`timescale 1ns/1ps
`default_nettype none
interface cphc_pfb_if #(parameter int W = 64) ();
	logic         push_valid;
	logic         push_ready;
	logic         spare;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;
	logic         flush;
	modport ctrl (output push_valid, push_data, pop_ready, flush,
		input push_ready, spare, pop_valid, pop_data);
	modport buffer (input push_valid, push_data, pop_ready, flush,
		output push_ready, spare, pop_valid, pop_data);
endinterface // cphc_pfb_if
`default_nettype wire

// *** cphc_pfb.sv ***
// cphc_pfb.sv: instruction prefetch buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "cphc_cfg.svh"
module cphc_pfb
	import cphc_pkg::*;
#(
	parameter int W     = 64,
	parameter int DEPTH = `CPHC_PFB_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input wire logic mclk,
	input wire logic rst_n,
	cphc_pfb_if.buffer p
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    ov;
		logic [W-1:0]            od;
	} cphc_pfb_st_s;
	cphc_pfb_st_s r, n;
	logic         push, pop, ld;

	assign p.push_ready = (r.cnt != (AW+1)'(DEPTH));
	assign p.spare      = (r.cnt < (AW+1)'(DEPTH - 1));
	assign p.pop_valid  = r.ov;
	assign p.pop_data   = r.od;
	assign push = p.push_valid && p.push_ready;
	assign pop  = r.ov && p.pop_ready;
	assign ld   = (!r.ov || pop) && (r.cnt != '0);

	// ============================================================
	// storage and output register
	always_comb begin
		n = r;
		if (pop)
			n.ov = 1'b0;
		if (push) begin
			n.mem[r.wp] = p.push_data;
			n.wp = r.wp + 1'b1;
		end
		if (ld) begin
			n.od = r.mem[r.rp];
			n.ov = 1'b1;
			n.rp = r.rp + 1'b1;
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(ld);
		if (p.flush) begin
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
			n.ov  = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	property p_flush_empty;
		@(posedge mclk) disable iff (!rst_n)
		p.flush |=> !p.pop_valid;
	endproperty
	a_flush_empty: assert property (p_flush_empty)
		else $error("prefetch data survived a flush");
endmodule // cphc_pfb
`default_nettype wire

// *** cphc_pipe_ctrl.sv ***
// cphc_pipe_ctrl.sv: pipeline advance, hazard stalls and fetch control
`timescale 1ns/1ps
`default_nettype none
`include "cphc_cfg.svh"
module cphc_pipe_ctrl
	import cphc_pkg::*;
#(
	parameter bit pipeline_depth_select = 1'b0,
	parameter int PFB_DEPTH             = `CPHC_PFB_DEPTH
) (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	output logic                     imem_req,
	output logic [`CPHC_AW-1:0]      imem_addr,
	input  wire logic                imem_ack,
	input  wire logic [`CPHC_IW-1:0] imem_rdata,
	input  wire logic                dmem_wait,
	input  wire logic                exu_done,
	input  wire logic                strm_wait,
	input  wire logic                br_taken,
	input  wire logic [`CPHC_AW-1:0] br_target,
	output logic                     ex_valid,
	output logic [`CPHC_AW-1:0]      ex_pc,
	output logic [`CPHC_IW-1:0]      ex_instr,
	output cphc_fwd_e                ex_fwd_a,
	output cphc_fwd_e                ex_fwd_b,
	output logic                     mem_valid,
	output logic [`CPHC_IW-1:0]      mem_instr,
	output logic                     wb_valid,
	output logic [`CPHC_IW-1:0]      wb_instr,
	output logic                     retire,
	output logic                     stall
);
	localparam bit THREE = pipeline_depth_select;

	typedef struct packed {
		cphc_stage_s         f;
		cphc_stage_s         d;
		cphc_stage_s         e;
		cphc_stage_s         m;
		cphc_stage_s         w;
		cphc_fwd_e           fa;
		cphc_fwd_e           fb;
		logic                req;
		logic                discard;
		logic [`CPHC_AW-1:0] addr;
		logic [`CPHC_AW-1:0] npc;
		logic                ret;
		logic                stall;
	} cphc_pipe_st_s;

	cphc_pipe_st_s r, n;
	cphc_pfb_if #(.W(`CPHC_AW + `CPHC_IW)) pf ();

	cphc_pfb #(
		.W     (`CPHC_AW + `CPHC_IW),
		.DEPTH (PFB_DEPTH)
	) u_pfb (
		.mclk  (mclk),
		.rst_n (rst_n),
		.p     (pf)
	);

	// ============================================================
	// instruction field decode
	function automatic cphc_cls_e cls(input cphc_stage_s s);
		return cphc_cls_e'(s.instr[`CPHC_CLS_HI:`CPHC_CLS_LO]);
	endfunction
	function automatic logic [4:0] rdf(input cphc_stage_s s);
		return s.instr[`CPHC_RD_HI:`CPHC_RD_LO];
	endfunction
	function automatic logic [4:0] raf(input cphc_stage_s s);
		return s.instr[`CPHC_RA_HI:`CPHC_RA_LO];
	endfunction
	function automatic logic [4:0] rbf(input cphc_stage_s s);
		return s.instr[`CPHC_RB_HI:`CPHC_RB_LO];
	endfunction
	// producer p writes a register that source register src reads
	function automatic logic hits(input cphc_stage_s p,
		input logic [4:0] src);
		return p.valid && rdf(p) != `CPHC_REG_ZERO && rdf(p) == src
			&& !(cls(p) inside {CPHC_STREAM, CPHC_BRANCH, CPHC_MEMORY_BARRIER_INSTR,
			CPHC_BRI});
	endfunction
	function automatic cphc_fwd_e fwd(input cphc_pipe_st_s s,
		input logic [4:0] src);
		if (hits(s.e, src))
			return CPHC_FWD_EX;
		else if (hits(s.m, src))
			return CPHC_FWD_MEM;
		else if (hits(s.w, src))
			return CPHC_FWD_WB;
		return CPHC_FWD_NONE;
	endfunction

	// ============================================================
	// hazard detection
	logic hz_e, hz_m, data_haz, mc, hold_m, hold_e, hold_d;
	logic take, sync, redirect, issue, push;
	logic [`CPHC_AW-1:0] raddr;

	assign hz_e = cls(r.e) inside {CPHC_LOAD, CPHC_STORE, CPHC_BSHIFT,
		CPHC_MUL, CPHC_DIV, CPHC_FPU}
		&& (hits(r.e, raf(r.d)) || hits(r.e, rbf(r.d)));
	assign hz_m = cls(r.m) inside {CPHC_LOAD, CPHC_MUL, CPHC_FPU}
		&& (hits(r.m, raf(r.d)) || hits(r.m, rbf(r.d)));
	// no interlock on registers at all in the short pipeline
	assign data_haz = !THREE && r.d.valid && (hz_e || hz_m);
	assign mc = r.e.valid && (THREE
		? cls(r.e) inside {CPHC_BSHIFT, CPHC_MUL, CPHC_DIV, CPHC_FPU}
		: cls(r.e) inside {CPHC_DIV, CPHC_FPU});
	assign hold_m = !THREE && r.m.valid && dmem_wait
		&& cls(r.m) inside {CPHC_LOAD, CPHC_STORE};
	// every cause just ORs in, so overlapping stalls do not add up
	assign hold_e = hold_m || (mc && !exu_done)
		|| (r.e.valid && cls(r.e) == CPHC_STREAM && strm_wait)
		|| (THREE && r.e.valid && dmem_wait
		&& cls(r.e) inside {CPHC_LOAD, CPHC_STORE});
	assign hold_d = hold_e || data_haz;

	// ============================================================
	// control flow changes leaving execute
	assign take = r.e.valid && !hold_e && br_taken
		&& cls(r.e) == CPHC_BRANCH;
	assign sync = r.e.valid && !hold_e && (cls(r.e) == CPHC_MEMORY_BARRIER_INSTR
		|| (cls(r.e) == CPHC_BRI
		&& r.e.instr[`CPHC_IMM_HI:`CPHC_IMM_LO] == `CPHC_SYNC_IMM));
	assign redirect = take || sync;
	assign raddr = take ? br_target : r.e.pc + `CPHC_PC_STEP;

	// ============================================================
	// prefetch traffic; fetch requests independent of decode stalls, pops wait for decode
	assign push = r.req && imem_ack && !r.discard && !redirect;
	assign issue = !redirect
		&& (r.req ? (imem_ack && pf.spare) : pf.push_ready);
	assign pf.push_valid = push;
	assign pf.push_data  = {r.addr, imem_rdata};
	assign pf.flush      = redirect;
	assign pf.pop_ready  = (!hold_d || !r.f.valid) && !redirect;

	// ============================================================
	// next state
	always_comb begin
		n = r;
		// writeback and memory stages, unused in the short pipeline
		n.w = hold_m ? '0 : r.m;
		n.m = hold_m ? r.m : ((hold_e || THREE) ? '0 : r.e);
		// execute takes decode unless held; a bubble follows a stall
		if (!hold_e) begin
			n.e  = (hold_d || redirect) ? '0 : r.d;
			n.fa = (hold_d || redirect) ? CPHC_FWD_NONE : fwd(r, raf(r.d));
			n.fb = (hold_d || redirect) ? CPHC_FWD_NONE : fwd(r, rbf(r.d));
			if (THREE && !hold_d && !redirect) begin
				n.fa = (fwd(r, raf(r.d)) == CPHC_FWD_EX) ? CPHC_FWD_EX
					: CPHC_FWD_NONE;
				n.fb = (fwd(r, rbf(r.d)) == CPHC_FWD_EX) ? CPHC_FWD_EX
					: CPHC_FWD_NONE;
			end
		end
		if (!hold_d)
			n.d = r.f;
		if (pf.pop_valid && pf.pop_ready)
			n.f = {1'b1, pf.pop_data};
		else if (!hold_d)
			n.f = '0;
		if (redirect) begin
			n.f = '0;
			n.d = '0;
			n.npc = raddr;
		end
		// fetch request, one outstanding at a time
		if (r.req && imem_ack) begin
			n.req = 1'b0;
			n.discard = 1'b0;
		end
		if (redirect && r.req && !imem_ack)
			n.discard = 1'b1;
		if (issue) begin
			n.req = 1'b1;
			n.addr = r.npc;
			n.npc = r.npc + `CPHC_PC_STEP;
		end
		n.ret = THREE ? (r.e.valid && !hold_e)
			: (r.m.valid && !hold_m);
		n.stall = hold_d;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r     <= '0;
			r.npc <= `CPHC_RST_PC;
		end else begin
			r <= n;
		end
	end

	// ============================================================
	// outputs
	assign imem_req  = r.req;
	assign imem_addr = r.addr;
	assign ex_valid  = r.e.valid;
	assign ex_pc     = r.e.pc;
	assign ex_instr  = r.e.instr;
	assign ex_fwd_a  = r.fa;
	assign ex_fwd_b  = r.fb;
	assign mem_valid = r.m.valid;
	assign mem_instr = r.m.instr;
	assign wb_valid  = r.w.valid;
	assign wb_instr  = r.w.instr;
	assign retire    = r.ret;
	assign stall     = r.stall;

	// ============================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_front_empty;
		!r.f.valid && !r.d.valid;
	endsequence
	sequence s_bubble_in_ex;
		!r.e.valid && r.fa == CPHC_FWD_NONE
			&& r.fb == CPHC_FWD_NONE;
	endsequence

	property p_advance;
		(r.d.valid && !hold_d && !redirect) |=> r.e.valid
			##1 ($past(hold_e) || (THREE ? retire : r.m.valid));
	endproperty
	a_advance: assert property (p_advance)
		else $error("instruction did not advance");

	property p_haz_bubble;
		(data_haz && !hold_e) |=> s_bubble_in_ex;
	endproperty
	a_haz_bubble: assert property (p_haz_bubble)
		else $error("dependent instruction left decode too early");

	property p_branch;
		take |=> s_front_empty ##0 (r.npc == $past(br_target));
	endproperty
	a_branch: assert property (p_branch)
		else $error("taken branch left old instructions");

	property p_multi;
		(mc && !exu_done && !hold_m) |=> r.e.valid
			&& (r.e.pc == $past(r.e.pc)) && $stable(r.d);
	endproperty
	a_multi: assert property (p_multi)
		else $error("multi-cycle instruction did not hold");

	property p_slow_data;
		hold_m |=> (r.m == $past(r.m)) && !r.w.valid;
	endproperty
	a_slow_data: assert property (p_slow_data)
		else $error("slow data access did not hold memory stage");

	property p_prefetch;
		(hold_d && !r.req && pf.push_ready && !redirect) |=> r.req;
	endproperty
	a_prefetch: assert property (p_prefetch)
		else $error("fetch stopped during a stall");

	property p_resume;
		(pf.pop_valid && !r.f.valid && !redirect) |=> r.f.valid;
	endproperty
	a_resume: assert property (p_resume)
		else $error("buffered instruction not taken");

	property p_sync;
		sync |=> s_front_empty ##0 !pf.pop_valid;
	endproperty
	a_sync: assert property (p_sync)
		else $error("barrier did not empty prefetch");

	property p_three;
		THREE |-> !r.m.valid && !r.w.valid && !data_haz;
	endproperty
	a_three: assert property (p_three)
		else $error("short pipeline used long stages");

	property p_mem_haz;
		(hz_m && !hz_e && r.d.valid && !hold_e && !THREE)
			|=> !hz_m;
	endproperty
	a_mem_haz: assert property (p_mem_haz)
		else $error("memory stage hazard lasted over one cycle");

	property p_redirect_bubble;
		redirect |=> !r.e.valid ##0 s_front_empty;
	endproperty
	a_redirect_bubble: assert property (p_redirect_bubble)
		else $error("redirect left a stage filled");

	property p_short_multi;
		(THREE && r.e.valid && !exu_done
			&& cls(r.e) inside {CPHC_BSHIFT, CPHC_MUL})
			|=> r.e == $past(r.e);
	endproperty
	a_short_multi: assert property (p_short_multi)
		else $error("short pipe shift or multiply not held");

	property p_long_single;
		(!THREE && r.e.valid && !dmem_wait
			&& cls(r.e) inside {CPHC_BSHIFT, CPHC_MUL})
			|=> r.m == $past(r.e);
	endproperty
	a_long_single: assert property (p_long_single)
		else $error("long pipe shift or multiply held execute");

	property p_slow_fetch;
		(!hold_d && !pf.pop_valid) |=> !r.f.valid;
	endproperty
	a_slow_fetch: assert property (p_slow_fetch)
		else $error("fetch stage filled without fetched data");

	property p_stream;
		(r.e.valid && cls(r.e) == CPHC_STREAM && strm_wait)
			|=> r.e == $past(r.e);
	endproperty
	a_stream: assert property (p_stream)
		else $error("waiting stream access left execute");

	property p_bubble_on;
		(hold_d && !hold_e) |=> !r.e.valid;
	endproperty
	a_bubble_on: assert property (p_bubble_on)
		else $error("no bubble behind a held decode stage");

	property p_retire;
		(!THREE && r.m.valid && !hold_m) |=> retire && wb_valid;
	endproperty
	a_retire: assert property (p_retire)
		else $error("memory stage instruction did not retire");
endmodule // cphc_pipe_ctrl
`default_nettype wire

// *** cphc_imem_model.sv ***
// cphc_imem_model.sv: instruction memory model with adjustable delay
`timescale 1ns/1ps
`default_nettype none
module cphc_imem_model (
	input  wire logic        mclk,
	input  wire logic        imem_req,
	input  wire logic [31:0] imem_addr,
	input  wire logic [31:0] prog [64],
	input  wire logic [1:0]  lat,
	output logic             imem_ack,
	output logic [31:0]      imem_rdata,
	output var int           hits [64]
);
	// ============================================================
	// answer
	logic        req_d = 1'b0;
	logic [31:0] junk  = 32'h5a5a_a5a5;
	int          cnt   = 0;
	initial hits = '{default: 0};
	// never answer in the cycle where a request first rises
	assign imem_ack   = imem_req && req_d && cnt >= int'(lat);
	// outside an answer the data lines carry a changing pattern
	assign imem_rdata = imem_ack ? prog[imem_addr[7:2]] : junk;
	always @(posedge mclk) begin
		req_d <= imem_req;
		junk  <= ~junk;
		cnt   <= (imem_ack || !imem_req) ? 0 : cnt + 1;
		if (imem_ack)
			hits[imem_addr[7:2]] <= hits[imem_addr[7:2]] + 1;
	end
endmodule // cphc_imem_model
`default_nettype wire

// *** cphc_pipe_ctrl_test.sv ***
// cphc_pipe_ctrl_test.sv: self-checking bench for the hazard control block
`timescale 1ns/1ps
`default_nettype none
module cphc_pipe_ctrl_test
	import cphc_pkg::*;
;
	// ============================================================
	// signals
	logic        mclk      = 1'b0;
	logic        rst_n     = 1'b0;
	logic        dmem_wait = 1'b0;
	logic        exu_done  = 1'b1;
	logic        strm_wait = 1'b0;
	logic        br_taken  = 1'b0;
	logic [31:0] br_target = 32'h0;
	logic [1:0]  lat       = 2'h0;
	logic        rnd_en    = 1'b0;
	logic [31:0] fwd_w     = 32'hffff_ffff;
	logic [31:0] prog [64];
	logic [31:0] exp_q [$];
	int          wb_t [$];
	int          hits [64];
	int          hits3 [64];
	int          seed        = 92267;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cyc         = 0;
	int          st_n        = 0;
	int          st3_n       = 0;
	logic        req, ack, req3, ack3;
	logic [31:0] addr, rdata, addr3, rdata3, ex_instr, wb_instr, ex_pc;
	logic [31:0] mem_instr;
	logic [31:0] mem_prev  = 32'hffff_ffff;
	logic        ex_valid, mem_valid, wb_valid, stall, stall3, mv3, wv3;
	logic        retire;
	cphc_fwd_e   fwd_a, fwd_b;
	// ============================================================
	// design and memories
	cphc_pipe_ctrl #(.pipeline_depth_select(1'b0)) DUT (.mclk, .rst_n,
		.imem_req(req), .imem_addr(addr), .imem_ack(ack), .imem_rdata(rdata),
		.dmem_wait, .exu_done, .strm_wait, .br_taken, .br_target, .ex_valid,
		.ex_pc, .ex_instr, .ex_fwd_a(fwd_a), .ex_fwd_b(fwd_b), .mem_valid,
		.mem_instr, .wb_valid, .wb_instr, .retire, .stall);
	cphc_pipe_ctrl #(.pipeline_depth_select(1'b1)) DUT3 (.mclk, .rst_n,
		.imem_req(req3), .imem_addr(addr3), .imem_ack(ack3),
		.imem_rdata(rdata3), .dmem_wait, .exu_done, .strm_wait, .br_taken,
		.br_target, .ex_valid(), .ex_pc(), .ex_instr(), .ex_fwd_a(),
		.ex_fwd_b(), .mem_valid(mv3), .mem_instr(), .wb_valid(wv3),
		.wb_instr(), .retire(), .stall(stall3));
	cphc_imem_model M (.mclk, .imem_req(req), .imem_addr(addr), .prog, .lat,
		.imem_ack(ack), .imem_rdata(rdata), .hits);
	cphc_imem_model M3 (.mclk, .imem_req(req3), .imem_addr(addr3), .prog,
		.lat, .imem_ack(ack3), .imem_rdata(rdata3), .hits(hits3));
	initial begin
		forever #2 mclk = ~mclk;
	end
	// ============================================================
	// helpers
	function automatic logic [31:0] w(input cphc_cls_e c, input int rd,
		input int ra, input int rb, input int im);
		return {c, rd[4:0], ra[4:0], rb[4:0], im[12:0]};
	endfunction
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask
	task automatic fill();
		for (int i = 0; i < 64; i++)
			prog[i] = w(CPHC_ALU, 0, 0, 0, i);
	endtask
	task automatic start(input logic [1:0] l);
		@(negedge mclk);
		rst_n = 1'b0;
		lat = l;
		exp_q.delete();
		wb_t.delete();
		repeat (5) @(negedge mclk);
		st_n = 0;
		st3_n = 0;
		rst_n = 1'b1;
	endtask
	task automatic exp_range(input int a, input int b);
		for (int i = a; i <= b; i++)
			exp_q.push_back(prog[i]);
	endtask
	task automatic finish_test(input string name);
		for (int i = 0; i < 600 && exp_q.size() > 0; i++)
			@(negedge mclk);
		check(exp_q.size() == 0, "instructions never retired");
		$display("test %s finished", name);
	endtask
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ============================================================
	// result watcher, random waits and time limit
	always @(negedge mclk) begin
		if (rst_n) begin
			check(mv3 === 1'b0 && wv3 === 1'b0, "late stage in short pipe");
			st_n += int'(stall === 1'b1);
			st3_n += int'(stall3 === 1'b1);
			check(retire === wb_valid, "retire flag wrong");
			if (ex_valid === 1'b1 && ex_instr === fwd_w) begin
				check(fwd_a !== CPHC_FWD_NONE, "operand a not forwarded");
				check(fwd_b !== CPHC_FWD_NONE, "operand b not forwarded");
				check(ex_pc === 32'h0000_0008, "execute address wrong");
			end
			if (wb_valid === 1'b1 && exp_q.size() > 0) begin
				check(wb_instr === exp_q[0], "retired word wrong");
				check(mem_prev === exp_q[0], "memory stage word wrong");
				void'(exp_q.pop_front());
				wb_t.push_back(cyc);
			end
			mem_prev = (mem_valid === 1'b1) ? mem_instr : 32'hffff_ffff;
		end
	end
	always @(negedge mclk) begin
		if (rnd_en) begin
			dmem_wait <= ($random(seed) & 3) == 0;
			strm_wait <= ($random(seed) & 3) == 0;
			exu_done  <= 1'($random(seed));
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	// ============================================================
	// tests
	initial begin
		int n;
		int h22;
		int h25;
		fill();
		start(2'h0);
		exp_range(0, 15);
		finish_test("throughput");
		check(wb_t[15] - wb_t[0] == 15, "not one retire per cycle");
		prog[1] = w(CPHC_ALU, 3, 0, 0, 1);
		prog[2] = w(CPHC_ALU, 6, 3, 3, 2);
		prog[3] = w(CPHC_LOAD, 4, 0, 0, 3);
		prog[4] = w(CPHC_ALU, 7, 0, 4, 4);
		prog[6] = w(CPHC_MUL, 5, 0, 0, 6);
		prog[8] = w(CPHC_ALU, 8, 5, 0, 8);
		fwd_w = prog[2];
		start(2'h0);
		exp_range(0, 12);
		finish_test("hazards");
		fwd_w = 32'hffff_ffff;
		check(st_n > 0, "no stall behind load or multiply");
		check(st3_n == 0, "short pipe stalled on data");
		fill();
		prog[1] = w(CPHC_BSHIFT, 10, 0, 0, 1);
		prog[2] = w(CPHC_DIV, 9, 0, 0, 2);
		start(2'h2);
		exu_done = 1'b0;
		exp_range(0, 10);
		for (int i = 0; i < 100 && ex_instr !== prog[2]; i++)
			@(negedge mclk);
		n = hits.sum();
		repeat (10) @(negedge mclk);
		check(ex_instr === prog[2] && stall === 1'b1, "divide not held");
		check(hits.sum() > n, "fetch idle while held");
		check(stall3 === 1'b1, "short pipe shift not held");
		exu_done = 1'b1;
		for (int i = 0; i < 20 && ex_instr !== prog[3]; i++)
			@(negedge mclk);
		@(negedge mclk);
		check(ex_instr === prog[4], "gap after hold");
		@(negedge mclk);
		check(ex_instr === prog[5], "buffer not used on resume");
		finish_test("multi-cycle");
		fill();
		prog[1] = w(CPHC_BRANCH, 0, 0, 0, 1);
		prog[21] = w(CPHC_MEMORY_BARRIER_INSTR, 0, 0, 0, 21);
		prog[24] = w(CPHC_BRI, 0, 0, 0, 4);
		br_taken = 1'b1;
		br_target = 32'h0000_0050;
		start(2'h0);
		h22 = hits[22];
		h25 = hits[25];
		exp_range(0, 1);
		exp_range(20, 28);
		finish_test("flush");
		check(hits[22] - h22 > 1 && hits[25] - h25 > 1, "no refetch");
		br_taken = 1'b0;
		fill();
		for (int i = 0; i < 40; i++)
			prog[i] = w(cphc_cls_e'(4'($random(seed) & 7)), $random(seed) & 7,
				$random(seed) & 7, $random(seed) & 7, i);
		start(2'($random(seed)));
		rnd_en = 1'b1;
		exp_range(0, 39);
		finish_test("random");
		check(st_n > 0, "random waits never stalled");
		complete_run();
	end
endmodule // cphc_pipe_ctrl_test
`default_nettype wire
